// ### logic/mcsc_mux_channel_select_ctrl.v
// channel-select control for a 16-to-1 analog mux, parallel or serial front end
// assumes all pins asynchronous to mclk; analog switches driven by one-hot enables
//
// Functional notes
// RQ1 - break old connection before making new one
// RQ2 - driver exercises all addresses after power-up
// RQ3 - parallel select lines choose input index
// RQ4 - route new input within about 100 ns; code takes about 7 to 8 cycles, 140 to 160 ns
// RQ5 - parallel address accepted only while select low
// RQ6 - parallel chip select active low, pulled up
// RQ7 - 8-bit shift register samples on clock rise
// RQ8 - only low four bits pick channel
// RQ9 - serial data most significant bit first
// RQ10 - shifted bits leave on serial out in order
// RQ11 - bit 7 shown first; falls shift out next
// RQ12 - host holds frame select low while shifting
// RQ13 - decode loads when frame select rises
// RQ14 - serial port is slave only
// RQ15 - reset clears address to input zero
// RQ16 - reset holds analog pins high impedance
// RQ17 - after reset common output follows input zero
// RQ18 - hold reset low during power-up
// RQ19 - reset pin active low, pulled up
// RQ20 - frame select active low, pulled up
// RQ21 - host changes data on clock falls
// RQ22 - short frame loads current low bits
`timescale 1ns/1ns
`include "mcsc_defs.vh"
module mcsc_mux_channel_select_ctrl (
  // clock and reset
  input wire mclk,
  input wire nrst,
  // variant strap: 0 parallel, 1 serial
  input wire mode,
  // parallel front end
  input wire [3:0] sel_addr,
  input wire sel_cs_n,
  // serial front end, slave only
  input wire sclk,
  input wire mosi,
  input wire ss_n,
  output reg miso,
  // analog switch control
  output reg [15:0] input_sw_en,
  output reg common_output_en
);

  // three-stage synchronisers; stage 1 feeds only stage 2
  reg [3:0] addr_s1, addr_s2, addr_s3;
  reg cs_s1, cs_s2, cs_s3;
  reg sclk_s1, sclk_s2, sclk_s3;
  reg mosi_s1, mosi_s2, mosi_s3;
  reg ss_s1, ss_s2, ss_s3;
  reg [3:0] addr_q;
  reg cs_q, sclk_q, ss_q;
  reg [7:0] shreg;
  reg [3:0] target;
  reg [3:0] active;
  reg [2:0] bbm_cnt;
  reg [1:0] state;

  // sequencer states: switches off after reset, one on, all open
  localparam [1:0] ST_OFF = 2'b00;
  localparam [1:0] ST_ON = 2'b01;
  localparam [1:0] ST_BREAK = 2'b10;

  // open interval in cycles, cut to the counter width on purpose
  wire [31:0] bbm_full = `MCSC_BBM_CYC;
  wire [2:0] bbm_load = bbm_full[2:0];

  // one-hot decode, used for switch enables
  function [15:0] onehot;
    input [3:0] idx;
    begin
      onehot = 16'h0001 << idx;
    end
  endfunction

  // address lines; the agree check rides out skew between the bits
  always @(posedge mclk) begin
    if (!nrst) begin // level reset; an idle-high pin leaves logic running RQ19
      addr_s1 <= 4'h0;
      addr_s2 <= 4'h0;
      addr_s3 <= 4'h0;
      addr_q <= 4'h0;
    end else begin
      addr_s1 <= sel_addr;
      addr_s2 <= addr_s1;
      addr_s3 <= addr_s2;
      // a change counts once stages 2 and 3 agree
      if (addr_s2 == addr_s3)
        addr_q <= addr_s3;
    end
  end

  // chip select; reset value is the pulled-up, deselected level
  always @(posedge mclk) begin
    if (!nrst) begin
      cs_s1 <= 1'b1; // RQ6
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      cs_q <= 1'b1;
    end else begin
      cs_s1 <= sel_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      // glitches shorter than a cycle never reach the decode
      if (cs_s2 == cs_s3)
        cs_q <= cs_s3;
    end
  end

  // serial clock; half periods under two mclk would be lost
  always @(posedge mclk) begin
    if (!nrst) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      sclk_s1 <= sclk;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      // idle low after reset, so no false edge on release
      if (sclk_s2 == sclk_s3)
        sclk_q <= sclk_s3;
    end
  end

  // serial data; stable around rises, so no agree filter needed
  always @(posedge mclk) begin
    if (!nrst) begin
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      mosi_s3 <= 1'b0;
    end else begin
      mosi_s1 <= mosi;
      mosi_s2 <= mosi_s1;
      mosi_s3 <= mosi_s2;
    end
  end

  // frame select; idle high keeps the shift window shut
  always @(posedge mclk) begin
    if (!nrst) begin
      ss_s1 <= 1'b1; // RQ20
      ss_s2 <= 1'b1;
      ss_s3 <= 1'b1;
      ss_q <= 1'b1;
    end else begin
      ss_s1 <= ss_n;
      ss_s2 <= ss_s1;
      ss_s3 <= ss_s2;
      // the rise is what loads the decode, so filter it
      if (ss_s2 == ss_s3)
        ss_q <= ss_s3;
    end
  end

  // edge events on the filtered serial pins
  wire sclk_rise = (sclk_s2 == sclk_s3) && sclk_s3 && !sclk_q;
  wire sclk_fall = (sclk_s2 == sclk_s3) && !sclk_s3 && sclk_q;
  wire ss_rise = (ss_s2 == ss_s3) && ss_s3 && !ss_q;

  // serial shift register and its output; slave only, never drives clock RQ14
  always @(posedge mclk) begin
    if (!nrst) begin
      shreg <= 8'h00; // RQ15
      miso <= 1'b0;
    end else begin
      if (mode == `MCSC_MODE_SER && !ss_q && sclk_rise)
        shreg <= {shreg[6:0], mosi_s3}; // RQ7 RQ9
      // miso holds bit 7 until a fall; after eight bits the first shifted shows RQ10
      if (mode == `MCSC_MODE_SER && sclk_fall)
        miso <= shreg[7]; // RQ11
      else if (mode == `MCSC_MODE_SER && ss_q)
        miso <= shreg[7]; // RQ11
    end
  end

  // pick the requested channel from whichever front end is strapped
  always @(posedge mclk) begin
    if (!nrst) begin
      target <= `MCSC_RST_CH; // RQ15
    end else if (mode == `MCSC_MODE_SER) begin
      if (ss_rise)
        target <= shreg[3:0]; // RQ8 RQ13 RQ22
    end else if (!cs_q) begin
      target <= addr_q; // RQ3 RQ5
    end
  end

  // break-before-make sequencer: all switches open, wait, then close new one
  always @(posedge mclk) begin
    if (!nrst) begin
      state <= ST_OFF;
      active <= `MCSC_RST_CH;
      bbm_cnt <= 3'h0;
      input_sw_en <= 16'h0000; // RQ16
      common_output_en <= 1'b0; // RQ16
    end else begin
      case (state)
        ST_OFF: begin
          // first cycle after release: input 0 and common out come up
          input_sw_en <= onehot(active); // RQ17
          common_output_en <= 1'b1; // RQ17
          state <= ST_ON;
        end
        ST_ON: begin
          if (target != active) begin
            input_sw_en <= 16'h0000; // RQ1
            active <= target;
            bbm_cnt <= bbm_load;
            state <= ST_BREAK;
          end
        end
        ST_BREAK: begin
          // total path about 7 to 8 cycles, past the 100 ns route budget; new requests wait
          if (bbm_cnt == 3'h1) begin
            input_sw_en <= onehot(active); // RQ1 RQ4
            state <= ST_ON;
          end
          bbm_cnt <= bbm_cnt - 3'h1;
        end
        default: begin
          state <= ST_OFF;
        end
      endcase
    end
  end

endmodule // mcsc_mux_channel_select_ctrl

// ### logic/mcsc_defs.vh
// constants for the mux channel-select controller
// assumes a 50 MHz core clock; included by the design file only
`ifndef MCSC_DEFS_VH
`define MCSC_DEFS_VH
`define MCSC_CLK_NS 20
`define MCSC_BBM_NS 40
`define MCSC_BBM_CYC ((`MCSC_BBM_NS + `MCSC_CLK_NS - 1) / `MCSC_CLK_NS)
`define MCSC_ROUTE_NS 100
`define MCSC_ROUTE_CYC (`MCSC_ROUTE_NS / `MCSC_CLK_NS)
`define MCSC_SHIFT_W 8
`define MCSC_CH_W 4
`define MCSC_CH_N 16
`define MCSC_RST_CH 4'h0
`define MCSC_MODE_PAR 1'b0
`define MCSC_MODE_SER 1'b1
`endif

// ### test/mcsc_checker.sv
// pin-level assertions for the mux channel-select controller
// assumes it is bound to the controller top; its ports match the controller pins
`timescale 1ns/1ns
module mcsc_checker(
  // clock, reset, strap and pins
  input wire mclk,
  input wire nrst,
  input wire mode,
  // parallel pins
  input wire [3:0] sel_addr,
  input wire sel_cs_n,
  // serial pins
  input wire sclk,
  input wire ss_n,
  input wire miso,
  // switch controls
  input wire [15:0] input_sw_en,
  input wire common_output_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // address held long enough to clear the synchronisers
  sequence s_steady;
    (!mode && !sel_cs_n && $stable(sel_addr)) [*8];
  endsequence
  a_one_hot: assert property ($onehot0(input_sw_en)) else $error("two on");
  a_brk_gap:
    assert property ($changed(input_sw_en) && |input_sw_en |-> $past(input_sw_en) == 0)
      else $error("no gap");
  a_rst_open:
    assert property (disable iff (1'b0) !nrst |=> input_sw_en == 0 && !common_output_en)
      else $error("not open");
  a_rst_zero:
    assert property ($rose(nrst) |=> input_sw_en == 16'h0001 && common_output_en)
      else $error("not input 0");
  a_par_route:
    assert property (s_steady |-> ##[0:3] input_sw_en == 16'h0001 << sel_addr)
      else $error("bad route");
  a_cs_hold:
    assert property ((!mode && sel_cs_n) [*8] |=> $stable(input_sw_en)) else $error("moved");
  a_ss_hold:
    assert property ((mode && !ss_n) [*8] |=> $stable(input_sw_en)) else $error("early");
  a_miso_hold:
    assert property ((mode && sclk && !ss_n) [*3] |=> $stable(miso)) else $error("miso");
endmodule // mcsc_checker
bind mcsc_mux_channel_select_ctrl mcsc_checker mcsc_checker_inst(.*);

// ### test/mcsc_host.sv
// spi master model: sclk idles low, 160 ns period, msb first
// assumes the slave samples on rises and shifts out on falls
`timescale 1ns/1ns
module mcsc_host(
  // spi lines
  output logic sclk,
  output logic mosi,
  output logic ss_n,
  input wire logic miso
);
  initial begin
    sclk = 0;
    mosi = 0;
    ss_n = 1;
  end
  // miso read late in the high phase, clear of the slave sync delay
  task xfer(input logic [7:0] tx, output logic [7:0] rx);
    ss_n = 0;
    mosi = tx[7];
    #80;
    for (int i = 0; i < 8; i++) begin
      sclk = 1;
      #80;
      rx = {rx[6:0], miso};
      sclk = 0;
      tx = tx << 1;
      mosi = tx[7];
      #80;
    end
    ss_n = 1;
    mosi = ~mosi;
  endtask
  // short frame of n bits, top bits of tx first
  task xfer_bits(input logic [7:0] tx, input int n);
    ss_n = 0;
    mosi = tx[7];
    #80;
    for (int i = 0; i < n; i++) begin
      sclk = 1;
      #80;
      sclk = 0;
      tx = tx << 1;
      mosi = tx[7];
      #80;
    end
    ss_n = 1;
    mosi = ~mosi;
  endtask
endmodule // mcsc_host

// ### test/tb_top.sv
// testbench for the mux channel-select controller, both variants
// assumes the checker is bound in and the spi host model is present
`timescale 1ns/1ns
module tb_top;
  logic mclk = 0, nrst = 0, mode = 0, cs_n = 1, sclk, mosi, ss_n, miso, coe;
  logic [3:0] addr = 0;
  logic [15:0] sw;
  logic [7:0] rx;
  int err_total = 0, comparisons = 0;
  initial forever #10 mclk = ~mclk;
  mcsc_mux_channel_select_ctrl mcsc_mux_channel_select_ctrl_inst(.mclk, .nrst, .mode,
    .sel_addr(addr), .sel_cs_n(cs_n), .sclk, .mosi, .ss_n, .miso, .input_sw_en(sw),
    .common_output_en(coe));
  mcsc_host mcsc_host_inst(.sclk, .mosi, .ss_n, .miso);
  task chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task t_rst(logic m);
    nrst = 0;
    mode = m;
    cyc(3);
    chk("sw", 0, sw);
    chk("com", 0, {15'h0000, coe});
    nrst = 1;
    cyc(1);
    chk("sw", 16'h0001, sw);
    chk("com", 16'h0001, {15'h0000, coe});
    $display("reset test done");
  endtask
  // every address once, ending back on zero
  task t_par;
    cs_n = 0;
    for (int a = 1; a < 17; a++) begin
      addr = 4'(a);
      cyc(10);
      chk("par", 16'h0001 << addr, sw);
    end
    cs_n = 1;
    cyc(5);
    addr = 4'h5;
    cyc(10);
    chk("hold", 16'h0001, sw);
    $display("parallel test done");
  endtask
  task t_ser;
    mcsc_host_inst.xfer(8'h09, rx);
    cyc(10);
    chk("ser", 16'h0200, sw);
    mcsc_host_inst.xfer(8'hf3, rx);
    chk("miso", 16'h0009, {8'h00, rx});
    cyc(10);
    chk("ser", 16'h0008, sw);
    mcsc_host_inst.xfer_bits(8'h50, 4);
    cyc(10);
    chk("short", 16'h0020, sw);
    $display("serial test done");
  endtask
  task end_sim;
    $display("%0d compares, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    t_rst(0);
    t_par;
    t_rst(1);
    t_ser;
    end_sim;
  end
  // tests need about 8 us
  initial begin
    #40000;
    err_total++;
    end_sim;
  end
endmodule // tb_top
